/* File: src/aieh_pkg.sv */
/*
  Constants, field positions and carrier types for the adapter internal-link error handler.
  Assumes both adapter halves and the internal link share one clock and one reset.
*/
package aieh_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W   = 30;
  localparam int STAT_W   = 8;
  localparam int VECTOR_W = 32;

  // ==========================================================
  // Bus-side error status bit positions
  localparam int BS_PARITY_BIT    = 0;
  localparam int BS_NULLIFIED_BIT = 1;
  localparam int BS_ILLEGAL_BIT   = 3;
  localparam int BS_MASTER_BIT    = 4;
  localparam int BS_CA_FETCH_BIT  = 6;

  // ==========================================================
  // System-side error status bit positions
  localparam int SS_DMA_B_CA_PAR_BIT = 1;
  localparam int SS_DMA_A_CA_PAR_BIT = 3;
  localparam int SS_IO_WR_FAIL_BIT   = 6;
  localparam int SS_INTERNAL_BIT     = 7;

  // ==========================================================
  // Reset values
  localparam logic [STAT_W-1:0]   STAT_RESET   = 8'h00;
  localparam logic [ADDR_W-1:0]   ADDR_RESET   = 30'h00000000;
  localparam logic [VECTOR_W-1:0] VECTOR_RESET = 32'h00000000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              valid;      // One-cycle strobe of an I/O C/A or ident cycle
    logic              io_read;    // I/O read flag
    logic              ident;      // Vector-identify cycle
    logic              parity_err; // Link parity error on this cycle
    logic              illegal;    // Reserved or illegal command decoded
    logic [ADDR_W-1:0] addr;       // Command address
  } aieh_io_cycle_t;

  typedef struct packed {
    logic              valid;      // One-cycle strobe of a DMA C/A cycle
    logic              cmd_bad;    // Command field undecodable
    logic              parity_err; // Link parity error on this cycle
    logic              nullify;    // Bus-side module nullifies it
    logic              channel_b;  // 1: channel B, 0: channel A
    logic [ADDR_W-1:0] addr;       // Expansion-bus address
  } aieh_dma_cycle_t;

  typedef struct packed {
    logic [STAT_W-1:0]   bus_status;
    logic [STAT_W-1:0]   sys_status;
    logic [ADDR_W-1:0]   io_log;
    logic [ADDR_W-1:0]   dma_log;
    logic                hand_valid;
    logic                hand_read;
    logic                hand_ident;
    logic                hand_ca_par;
    logic                hand_illegal;
    logic [ADDR_W-1:0]   hand_addr;
    logic                abort;
    logic                read_error_response;
    logic                vec_ret;
    logic [VECTOR_W-1:0] vec_data;
    logic                implied_vector_interrupt;
    logic                interrupt_message;
  } aieh_state_t;

endpackage : aieh_pkg

/* File: src/aieh_error_handler.sv */
/*
  Error handling for internal-link C/A, vector-identify and DMA C/A cycles, covering
  the bus-side module and the system-side module of the adapter in one block.
  Assumes cycle strobes come from logic on mclk_in and each valid lasts one cycle.
*/
`timescale 1ns/100ps

module aieh_error_handler (
  input  wire logic                            mclk_in,                        // 100 MHz clock
  input  wire logic                            rst_n_in,                       // Async reset, low
  input  wire aieh_pkg::aieh_io_cycle_t        io_cycle_in,                    // I/O C/A or ident cycle
  input  wire aieh_pkg::aieh_dma_cycle_t       dma_cycle_in,                   // DMA C/A cycle
  input  wire logic [aieh_pkg::VECTOR_W-1:0]   return_vector_value_in,         // Stored vector
  input  wire logic                            return_vector_disable_in,       // Control bit
  input  wire logic                            implied_vector_interrupt_enable_in,               // Mask bit
  input  wire logic                            bus_interrupt_message_enable_in,             // Bus-side enable
  input  wire logic [aieh_pkg::STAT_W-1:0]     bus_status_clear_in,            // Clear strobes
  input  wire logic [aieh_pkg::STAT_W-1:0]     sys_status_clear_in,            // Clear strobes
  output logic [aieh_pkg::STAT_W-1:0]          bus_side_error_status_out,      // Sticky bits
  output logic [aieh_pkg::STAT_W-1:0]          system_side_error_status_out,   // Sticky bits
  output logic [aieh_pkg::ADDR_W-1:0]          io_error_address_log_out,       // I/O address log
  output logic [aieh_pkg::ADDR_W-1:0]          dma_error_address_log_out,      // DMA address log
  output logic                                 abort_out,                      // Abort pulse
  output logic                                 read_error_response_out,        // Read-error pulse
  output logic                                 vector_return_out,              // Vector pulse
  output logic [aieh_pkg::VECTOR_W-1:0]        vector_data_out,                // Returned vector
  output logic                                 implied_vector_interrupt_out,   // Pulse
  output logic                                 interrupt_message_out           // Pulse
);
  import aieh_pkg::*;

  // ==========================================================
  // Sticky update: a set in the same cycle as a clear wins
  function automatic logic [STAT_W-1:0] sticky(input logic [STAT_W-1:0] cur,
                                               input logic [STAT_W-1:0] clr,
                                               input logic [STAT_W-1:0] set);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  function automatic logic [STAT_W-1:0] bit_at(input int pos);
    bit_at = STAT_W'(1) << pos;
  endfunction : bit_at

  aieh_state_t s_q;
  aieh_state_t s_d;

  logic [STAT_W-1:0] bus_set;
  logic [STAT_W-1:0] sys_set;
  logic              io_par_fail;
  logic              io_ill_fail;
  logic              dma_live;

  // ==========================================================
  // Next state
  always_comb begin
    s_d          = s_q;
    bus_set      = STAT_RESET;
    sys_set      = STAT_RESET;
    s_d.abort    = 1'b0;
    s_d.read_error_response      = 1'b0;
    s_d.vec_ret  = 1'b0;
    s_d.implied_vector_interrupt   = 1'b0;
    s_d.interrupt_message     = 1'b0;

    // Bus-side: parity only acts on read C/A and ident cycles
    io_par_fail = io_cycle_in.valid && io_cycle_in.parity_err &&
                  (io_cycle_in.io_read || io_cycle_in.ident);
    // Sticky parity bit blocks illegal-command handling
    io_ill_fail = io_cycle_in.valid && io_cycle_in.illegal && !io_cycle_in.parity_err &&
                  !s_q.bus_status[BS_PARITY_BIT];

    if (io_par_fail) begin
      bus_set = bus_set | bit_at(BS_PARITY_BIT) | bit_at(BS_CA_FETCH_BIT) |
                bit_at(BS_MASTER_BIT);
    end
    if (io_ill_fail) begin
      bus_set = bus_set | bit_at(BS_ILLEGAL_BIT);
    end
    s_d.abort        = io_par_fail || io_ill_fail;
    s_d.hand_valid   = io_par_fail || io_ill_fail;
    s_d.hand_read    = io_cycle_in.io_read;
    s_d.hand_ident   = io_cycle_in.ident;
    s_d.hand_ca_par  = io_par_fail;
    s_d.hand_illegal = io_ill_fail;
    s_d.hand_addr    = io_cycle_in.addr;

    // System-side: answer the failure handed over last cycle
    if (s_q.hand_valid) begin
      if (s_q.hand_ident && s_q.hand_ca_par) begin
        if (!return_vector_disable_in) begin
          s_d.vec_ret  = 1'b1;
          s_d.vec_data = return_vector_value_in;
        end else begin
          s_d.read_error_response = 1'b1;
        end
      end else if (s_q.hand_ca_par) begin
        s_d.read_error_response = 1'b1;
      end else if (s_q.hand_illegal && s_q.hand_read) begin
        s_d.read_error_response = 1'b1;
      end else if (s_q.hand_illegal) begin
        sys_set      = sys_set | bit_at(SS_IO_WR_FAIL_BIT);
        s_d.io_log   = s_q.hand_addr;
        s_d.implied_vector_interrupt   = implied_vector_interrupt_enable_in;
      end
    end

    // DMA C/A checked at the system side unless nullified
    dma_live = dma_cycle_in.valid && dma_cycle_in.cmd_bad;
    if (dma_live && dma_cycle_in.nullify) begin
      bus_set  = bus_set | bit_at(BS_NULLIFIED_BIT) |
                 (dma_cycle_in.parity_err ? bit_at(BS_PARITY_BIT) : STAT_RESET);
      s_d.interrupt_message = bus_interrupt_message_enable_in;
    end else if (dma_live && !dma_cycle_in.parity_err) begin
      sys_set     = sys_set | bit_at(SS_INTERNAL_BIT);
      s_d.dma_log = dma_cycle_in.addr;
      s_d.implied_vector_interrupt  = implied_vector_interrupt_enable_in;
    end else if (dma_live) begin
      sys_set     = sys_set | (dma_cycle_in.channel_b ? bit_at(SS_DMA_B_CA_PAR_BIT)
                                                      : bit_at(SS_DMA_A_CA_PAR_BIT));
      s_d.dma_log = dma_cycle_in.addr;
      s_d.implied_vector_interrupt  = implied_vector_interrupt_enable_in;
    end

    s_d.bus_status = sticky(s_q.bus_status, bus_status_clear_in, bus_set);
    s_d.sys_status = sticky(s_q.sys_status, sys_status_clear_in, sys_set);
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q              <= '0;
      s_q.bus_status   <= STAT_RESET;
      s_q.sys_status   <= STAT_RESET;
      s_q.io_log       <= ADDR_RESET;
      s_q.dma_log      <= ADDR_RESET;
      s_q.vec_data     <= VECTOR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign bus_side_error_status_out    = s_q.bus_status;
  assign system_side_error_status_out = s_q.sys_status;
  assign io_error_address_log_out     = s_q.io_log;
  assign dma_error_address_log_out    = s_q.dma_log;
  assign abort_out                    = s_q.abort;
  assign read_error_response_out      = s_q.read_error_response;
  assign vector_return_out            = s_q.vec_ret;
  assign vector_data_out              = s_q.vec_data;
  assign implied_vector_interrupt_out = s_q.implied_vector_interrupt;
  assign interrupt_message_out        = s_q.interrupt_message;

endmodule : aieh_error_handler

/* File: tb/aieh_error_handler_props.sv */
/* Assertions for the internal-link error handler.
   Assumes one clock and the async active-low reset of the design. */
`timescale 1ns/100ps
module aieh_error_handler_props (
  input wire logic                        mclk_in, rst_n_in,      // Clock, reset
  input wire aieh_pkg::aieh_io_cycle_t    io_cycle_in,            // I/O cycle
  input wire aieh_pkg::aieh_dma_cycle_t   dma_cycle_in,           // DMA cycle
  input wire logic [31:0]                 return_vector_value_in, // Vector
  input wire logic                        return_vector_disable_in, implied_vector_interrupt_enable_in,
  input wire logic                        bus_interrupt_message_enable_in,     // Enables
  input wire logic [7:0]                  bus_status_clear_in, sys_status_clear_in,
  input wire logic [7:0]                  bus_side_error_status_out, system_side_error_status_out,
  input wire logic [29:0]                 io_error_address_log_out, dma_error_address_log_out,
  input wire logic                        abort_out, read_error_response_out, vector_return_out,
  input wire logic [31:0]                 vector_data_out,        // Vector out
  input wire logic                        implied_vector_interrupt_out, interrupt_message_out
);
  import aieh_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire io_p = io_cycle_in.valid && io_cycle_in.parity_err
              && (io_cycle_in.io_read || io_cycle_in.ident);
  wire io_i = io_cycle_in.valid && io_cycle_in.illegal && !io_cycle_in.parity_err
              && !bus_side_error_status_out[0];
  wire dm_b = dma_cycle_in.valid && dma_cycle_in.cmd_bad;
  // ==========================================================
  // I/O path
  property p_par; io_p |=> abort_out && (bus_side_error_status_out & 8'h51) == 8'h51; endproperty
  a_par: assert property (p_par) else $error("parity abort missing");
  property p_rd; io_p && !io_cycle_in.ident |=> ##1 read_error_response_out; endproperty
  a_rd: assert property (p_rd) else $error("read error missing");
  property p_vec;
    io_p && io_cycle_in.ident && !return_vector_disable_in
      |=> ##1 vector_return_out && vector_data_out == $past(return_vector_value_in);
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_vdis;
    io_p && io_cycle_in.ident && return_vector_disable_in
      |=> ##1 read_error_response_out && !vector_return_out;
  endproperty
  a_vdis: assert property (p_vdis) else $error("disabled vector answer wrong");
  property p_ill; io_i |=> abort_out && bus_side_error_status_out[3]; endproperty
  a_ill: assert property (p_ill) else $error("illegal abort missing");
  property p_ilw;
    io_i && !io_cycle_in.io_read |=> ##1 system_side_error_status_out[6]
      && io_error_address_log_out == $past(io_cycle_in.addr, 2);
  endproperty
  a_ilw: assert property (p_ilw) else $error("write failure log wrong");
  property p_ilr; io_i && io_cycle_in.io_read |=> ##1 read_error_response_out; endproperty
  a_ilr: assert property (p_ilr) else $error("illegal read answer missing");
  // ==========================================================
  // DMA path and status stickiness
  property p_dcl;
    dm_b && !dma_cycle_in.parity_err && !dma_cycle_in.nullify |=> system_side_error_status_out[7]
      && dma_error_address_log_out == $past(dma_cycle_in.addr)
      && (implied_vector_interrupt_out || !$past(implied_vector_interrupt_enable_in));
  endproperty
  a_dcl: assert property (p_dcl) else $error("dma internal error wrong");
  property p_dnu;
    dm_b && dma_cycle_in.nullify |=> bus_side_error_status_out[1]
      && interrupt_message_out == $past(bus_interrupt_message_enable_in)
      && $stable(dma_error_address_log_out);
  endproperty
  a_dnu: assert property (p_dnu) else $error("nullified dma wrong");
  property p_dpa;
    dm_b && dma_cycle_in.parity_err && !dma_cycle_in.nullify
      |=> ($past(dma_cycle_in.channel_b) ? system_side_error_status_out[1]
           : system_side_error_status_out[3])
      && dma_error_address_log_out == $past(dma_cycle_in.addr);
  endproperty
  a_dpa: assert property (p_dpa) else $error("dma parity bit wrong");
  property p_stk;
    (($past(bus_side_error_status_out) & ~$past(bus_status_clear_in)
      & ~bus_side_error_status_out) | ($past(system_side_error_status_out)
      & ~$past(sys_status_clear_in) & ~system_side_error_status_out)) == 8'h00;
  endproperty
  a_stk: assert property (p_stk) else $error("status bit dropped");
endmodule : aieh_error_handler_props
bind aieh_error_handler aieh_error_handler_props u_props (.mclk_in, .rst_n_in, .io_cycle_in,
  .dma_cycle_in, .return_vector_value_in, .return_vector_disable_in, .implied_vector_interrupt_enable_in,
  .bus_interrupt_message_enable_in, .bus_status_clear_in, .sys_status_clear_in, .bus_side_error_status_out,
  .system_side_error_status_out, .io_error_address_log_out, .dma_error_address_log_out,
  .abort_out, .read_error_response_out, .vector_return_out, .vector_data_out,
  .implied_vector_interrupt_out, .interrupt_message_out);

/* File: tb/aieh_node_model.sv */
/* Requesting node: counts the answers it receives.
   Assumes answers are one-cycle pulses on the handler clock. */
`timescale 1ns/100ps
module aieh_node_model (
  input  wire logic mclk_in,     // Clock
  input  wire logic rst_n_in,    // Reset, low
  input  wire logic rer_in,      // Read-error answer
  input  wire logic vec_in,      // Vector answer
  output int        answers_out  // Answers taken
);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) answers_out <= 0;
    else if (rer_in || vec_in) answers_out <= answers_out + 1;
  end
endmodule : aieh_node_model

/* File: tb/test_aieh_error_handler.sv */
/* Self-checking bench for the internal-link error handler.
   Assumes the node model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module test_aieh_error_handler;
  import aieh_pkg::*;
  logic mclk_in = 0, rst_n_in = 0, dis = 0, iv = 1, bi = 1, ab, read_error_response, vr, ivi, msg;
  aieh_io_cycle_t io = '0;
  aieh_dma_cycle_t dm = '0;
  logic [31:0] rv = '0, vd;
  logic [7:0] bc = '0, sc = '0, bs, ss;
  logic [29:0] il, dl, a, p;
  logic [32:0] notes[$];
  int miscompares = 0, checks = 0, ans;
  aieh_error_handler dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .io_cycle_in(io),
    .dma_cycle_in(dm), .return_vector_value_in(rv), .return_vector_disable_in(dis),
    .implied_vector_interrupt_enable_in(iv), .bus_interrupt_message_enable_in(bi), .bus_status_clear_in(bc),
    .sys_status_clear_in(sc), .bus_side_error_status_out(bs), .system_side_error_status_out(ss),
    .io_error_address_log_out(il), .dma_error_address_log_out(dl), .abort_out(ab),
    .read_error_response_out(read_error_response), .vector_return_out(vr), .vector_data_out(vd),
    .implied_vector_interrupt_out(ivi), .interrupt_message_out(msg));
  aieh_node_model node (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .rer_in(read_error_response), .vec_in(vr),
    .answers_out(ans));
  initial forever #5 mclk_in = ~mclk_in;
  // ==========================================================
  // Shared tasks
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic cyc(bit d, logic r, logic i, logic pe, logic x);
    a = $urandom;
    @(negedge mclk_in);
    if (d) dm <= '{1'b1, 1'b1, pe, x, r, a};
    else io <= '{1'b1, r, i, pe, x, a};
    @(negedge mclk_in);
    io.valid <= 1'b0;
    dm.valid <= 1'b0;
  endtask : cyc
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Answers are matched oldest note first
  always @(negedge mclk_in) if (read_error_response === 1'b1 || vr === 1'b1) begin
    if (notes.size() == 0) chk("unexpected answer", 0, 1);
    else chk("answer", notes.pop_front(), {vr, vr ? vd : 32'h00000000});
  end
  initial begin
    repeat (3000) @(negedge mclk_in);
    miscompares++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h554D));
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1;
    chk("bus_status", 0, bs);
    notes.push_back('0);
    cyc(0, 1, 0, 1, 0);
    chk("bus_status", 8'h51, bs);
    chk("abort", 1, ab);
    rv = $urandom;
    notes.push_back({1'b1, rv});
    cyc(0, 0, 1, 1, 0);
    chk("bus_status", 8'h51, bs);
    @(negedge mclk_in);
    dis = 1;
    notes.push_back('0);
    cyc(0, 0, 1, 1, 0);
    cyc(0, 1, 0, 0, 1);
    chk("abort refused", 0, ab);
    bc = 8'hFF;
    @(negedge mclk_in);
    bc = 8'h00;
    chk("bus_status cleared", 0, bs);
    $display("test io parity done");
    cyc(0, 0, 0, 0, 1);
    chk("bus_status", 8'h08, bs);
    @(negedge mclk_in);
    chk("sys_status", 8'h40, ss);
    chk("io_log", a, il);
    chk("implied_vector_interrupt", 1, ivi);
    notes.push_back('0);
    cyc(0, 1, 0, 0, 1);
    $display("test illegal done");
    cyc(1, 0, 0, 0, 0);
    chk("sys_status", 8'hC0, ss);
    chk("dma_log", a, dl);
    for (int c = 0; c < 2; c++) begin
      iv = c[0];
      cyc(1, c[0], 0, 1, 0);
      chk("dma parity bit", 1, c ? ss[1] : ss[3]);
      chk("dma_log", a, dl);
      chk("implied_vector_interrupt", c[0], ivi);
    end
    p = dl;
    cyc(1, 0, 0, 0, 1);
    chk("nullified bit", 1, bs[1]);
    chk("message", 1, msg);
    chk("dma_log kept", p, dl);
    chk("sys_status sticky", 8'hCA, ss);
    bi = 0;
    cyc(1, 0, 0, 1, 1);
    chk("message masked", 0, msg);
    chk("nullified parity bit", 1, bs[0]);
    chk("dma_log kept", p, dl);
    $display("test dma done");
    for (int i = 0; i < 20 && notes.size() > 0; i++) @(negedge mclk_in);
    chk("notes left", 0, notes.size());
    chk("node answers", 4, ans);
    complete_run();
  end
endmodule : test_aieh_error_handler
